// ==== bench/e1ios_status_tb_top.sv ====
`timescale 1ns/1ps
module e1ios_status_tb_top;
	import e1ios_pkg::*;
	`define CHK(nm, ex, got) begin testsRun++; if ((got) !== (ex)) begin badCount++; $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
	// Short debounce keeps the run brief; expectations follow this value.
	localparam int DEB = 2;
	localparam int TWO_POS [6] = '{7, 6, 4, 3, 2, 1};
	localparam int LATCH_POS [6] = '{7, 6, 5, 3, 2, 1};
	logic sysClk = 1'b0;
	logic rstN;
	e1ios_req_t req;
	logic [7:0] rdData;
	logic irq;
	e1ios_ctr_t counters;
	logic [3:0] saBits;
	logic [3:0] saNibble;
	logic saNibbleStb;
	logic [2:0] linkCtrlIrq;
	logic jitterMargin;
	logic oneSecStatus;
	logic fiveSecStatus;
	logic remoteAlarm;
	logic crcError;
	logic [3:0] sigPattern;
	logic [7:0] m;
	logic [7:0] ex;
	int badCount = 0;
	int testsRun = 0;
	int cycles = 0;
	int seed = 32'hD02B6C86;

	////////////////////////////////////////////////////////////////////////////////
	// Device under test.
	e1ios_status #(.DEBOUNCE(DEB)) u_dut (
		.sys_clk(sysClk),
		.rst_n(rstN),
		.req(req),
		.rdData(rdData),
		.irq(irq),
		.counters(counters),
		.saBits(saBits),
		.saNibble(saNibble),
		.saNibbleStb(saNibbleStb),
		.linkCtrlIrq(linkCtrlIrq),
		.jitterMargin(jitterMargin),
		.oneSecStatus(oneSecStatus),
		.fiveSecStatus(fiveSecStatus),
		.remoteAlarm(remoteAlarm),
		.crcError(crcError),
		.sigPattern(sigPattern)
	);

	// A 20 ns clock.
	always #10 sysClk = ~sysClk;

	// A hang is cut short well above the few hundred cycles the run needs.
	always @(posedge sysClk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			badCount++;
			stopTest();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Expected status bit for an event at a position under a mask.
	function automatic logic [7:0] expBit(input int pos, input logic [7:0] mask);
		return mask[pos] ? (8'h01 << pos) : 8'h00;
	endfunction

	// One-cycle write strobe.
	task automatic regWrite(input logic [7:0] addr, input logic [7:0] data);
		@(posedge sysClk);
		req <= '{addr: addr, wrData: data, wr: 1'b1, rd: 1'b0};
		@(posedge sysClk);
		req.wr <= 1'b0;
	endtask

	// One-cycle read strobe; the data stand only in the following cycle, so look there.
	task automatic regRead(input logic [7:0] addr, input logic [7:0] expVal, input string nm);
		@(posedge sysClk);
		req.addr <= addr;
		req.rd <= 1'b1;
		@(posedge sysClk);
		req.rd <= 1'b0;
		#1;
		`CHK(nm, expVal, rdData)
	endtask

	// Step one counter low byte through FF then 00.
	task automatic wrapCounter(input int i);
		@(posedge sysClk);
		counters[47-8*i -: 8] <= COUNT_MAX;
		@(posedge sysClk);
		counters[47-8*i -: 8] <= COUNT_ZERO;
		@(posedge sysClk);
		#1;
	endtask

	// Raise one word three source; index 8 is a remote alarm without a CRC error.
	task automatic fireEvent(input int k);
		@(posedge sysClk);
		case (k)
			0, 1, 2: linkCtrlIrq[k] <= 1'b1;
			3: jitterMargin <= 1'b1;
			4: oneSecStatus <= 1'b1;
			5: fiveSecStatus <= 1'b1;
			6:
			begin
				remoteAlarm <= 1'b1;
				crcError <= 1'b1;
			end
			7: sigPattern <= ~sigPattern;
			default: remoteAlarm <= 1'b1;
		endcase
		@(posedge sysClk);
		{linkCtrlIrq, jitterMargin, oneSecStatus, fiveSecStatus, remoteAlarm, crcError} <= '0;
		@(posedge sysClk);
		#1;
	endtask

	// Present a nibble with its strobe for one cycle.
	task automatic strobeNibble(input logic [3:0] nib);
		@(posedge sysClk);
		saNibble <= nib;
		saNibbleStb <= 1'b1;
		@(posedge sysClk);
		saNibbleStb <= 1'b0;
	endtask

	// Print counts and the verdict, then end.
	task automatic stopTest();
		$display("Comparisons %0d, mismatches %0d", testsRun, badCount);
		if (badCount == 0 && testsRun > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset, counters, Sa, word three sources, debounce.
	initial
	begin
		req = '0;
		counters = '0;
		{saBits, saNibble, saNibbleStb, linkCtrlIrq, sigPattern} = '0;
		{jitterMargin, oneSecStatus, fiveSecStatus, remoteAlarm, crcError} = '0;
		rstN = 1'b0;
		repeat (16) @(posedge sysClk);
		rstN <= 1'b1;
		regRead(ADDR_WORD_TWO, STATUS_RESET, "word two reset");
		regRead(ADDR_WORD_THREE, STATUS_RESET, "word three reset");
		regRead(ADDR_OVF_LATCH, STATUS_RESET, "latch reset");
		regRead(8'h55, 8'h00, "unmapped read");
		`CHK("irq reset", 1'b0, irq)
		// Reset masks everything, yet the latch still records the wrap and holds it.
		wrapCounter(0);
		repeat (20) @(posedge sysClk);
		regRead(ADDR_WORD_TWO, 8'h00, "masked word two");
		regRead(ADDR_OVF_LATCH, 8'h80, "latch held");
		regRead(ADDR_OVF_LATCH, 8'h00, "latch cleared");
		// Every counter, first fully enabled, then under random masks.
		for (int j = 0; j < 12; j++)
		begin
			m = (j < 6) ? 8'hFF : 8'($random(seed));
			regWrite(ADDR_MASK_TWO, m);
			wrapCounter(j % 6);
			`CHK("irq on wrap", m[TWO_POS[j % 6]], irq)
			regRead(ADDR_WORD_TWO, expBit(TWO_POS[j % 6], m), "word two wrap");
			// The multiframe bit survives a read and needs a write of one.
			ex = expBit(TWO_POS[j % 6], m) & 8'h03;
			regRead(ADDR_WORD_TWO, ex, "word two read clear");
			regWrite(ADDR_WORD_TWO, 8'h03);
			regRead(ADDR_OVF_LATCH, expBit(LATCH_POS[j % 6], 8'hFF), "latch wrap");
		end
		// Sa change in bit mode, then in nibble mode where repeats and bit changes are ignored.
		regWrite(ADDR_MASK_TWO, 8'h01);
		regWrite(ADDR_CONTROL, 8'h10);
		@(posedge sysClk);
		saBits <= 4'h5;
		regRead(ADDR_WORD_TWO, 8'h01, "sa bit change");
		regRead(ADDR_WORD_TWO, 8'h01, "sa not read clear");
		regWrite(ADDR_WORD_TWO, 8'h01);
		regWrite(ADDR_CONTROL, 8'h00);
		strobeNibble(4'h3);
		regRead(ADDR_WORD_TWO, 8'h01, "sa nibble change");
		regWrite(ADDR_WORD_TWO, 8'h01);
		@(posedge sysClk);
		saBits <= 4'hA;
		strobeNibble(4'h3);
		regRead(ADDR_WORD_TWO, 8'h00, "sa nibble repeat");
		strobeNibble(4'hC);
		regRead(ADDR_WORD_TWO, 8'h01, "sa nibble new");
		// The Sa bit clears only by writing one, so clear it before the word three checks of the line.
		regWrite(ADDR_WORD_TWO, 8'h01);
		// Word three sources, first enabled, then under random masks.
		for (int j = 0; j < 18; j++)
		begin
			m = (j < 9) ? 8'hFF : 8'($random(seed));
			regWrite(ADDR_MASK_THREE, m);
			fireEvent(j % 9);
			ex = (j % 9 < 8) ? expBit(7 - j % 9, m) : 8'h00;
			`CHK("irq word three", ex != 8'h00, irq)
			regRead(ADDR_WORD_THREE, ex, "word three event");
			`CHK("irq after read", 1'b0, irq)
		end
		// Write-one clear removes only the bit written.
		regWrite(ADDR_MASK_THREE, 8'hFF);
		fireEvent(0);
		fireEvent(1);
		regWrite(ADDR_WORD_THREE, 8'h80);
		regRead(ADDR_WORD_THREE, 8'h40, "write one clear");
		// Debounce: a one-cycle glitch is dropped, a steady change reports once.
		regWrite(ADDR_CONTROL, 8'h01);
		@(posedge sysClk);
		sigPattern <= ~sigPattern;
		@(posedge sysClk);
		sigPattern <= ~sigPattern;
		repeat (6) @(posedge sysClk);
		regRead(ADDR_WORD_THREE, 8'h00, "debounce glitch");
		@(posedge sysClk);
		sigPattern <= ~sigPattern;
		repeat (6) @(posedge sysClk);
		regRead(ADDR_WORD_THREE, 8'h01, "debounce steady");
		stopTest();
	end
endmodule // e1ios_status_tb_top

// ==== rtl/e1ios_pkg.sv ====
package e1ios_pkg;
	// Register addresses on the 8-bit register port.
	localparam logic [7:0] ADDR_WORD_TWO = 8'h1D;
	localparam logic [7:0] ADDR_WORD_THREE = 8'h1E;
	localparam logic [7:0] ADDR_OVF_LATCH = 8'h1F;
	localparam logic [7:0] ADDR_MASK_TWO = 8'h0D;
	localparam logic [7:0] ADDR_MASK_THREE = 8'h0E;
	localparam logic [7:0] ADDR_CONTROL = 8'h0F;

	// Field positions in interrupt word two and the overflow latch.
	localparam int BIT_FRAME_ERR = 7;
	localparam int BIT_CRC_ERR = 6;
	localparam int BIT_EBIT = 4;
	localparam int BIT_EBIT_LATCH = 5;
	localparam int BIT_LINE_CODE = 3;
	localparam int BIT_PRBS_ERR = 2;
	localparam int BIT_PRBS_MF = 1;
	localparam int BIT_SA = 0;

	// Field positions in interrupt word three.
	localparam int BIT_LINK0 = 7;
	localparam int BIT_LINK1 = 6;
	localparam int BIT_LINK2 = 5;
	localparam int BIT_JITTER = 4;
	localparam int BIT_ONE_SEC = 3;
	localparam int BIT_FIVE_SEC = 2;
	localparam int BIT_RAI_CRC = 1;
	localparam int BIT_SIGNAL = 0;

	// Control register fields.
	localparam int BIT_SA_SELECT = 4;
	localparam int BIT_DEBOUNCE_EN = 0;

	// Bits that exist; all others read as zero.
	localparam logic [7:0] WORD_TWO_USED = 8'hDF;
	// Word two bits that a read clears; the multiframe and Sa bits clear only by writing one.
	localparam logic [7:0] WORD_TWO_READ_CLEAR = 8'hDC;
	localparam logic [7:0] LATCH_USED = 8'hEE;
	localparam logic [7:0] CONTROL_USED = 8'h11;

	// Reset values.
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;

	// Counter wrap points.
	localparam logic [7:0] COUNT_MAX = 8'hFF;
	localparam logic [7:0] COUNT_ZERO = 8'h00;

	// Debounce hold time in clock cycles.
	localparam int DEBOUNCE_CYCLES = 8;

	// Low bytes of the six monitored error counters.
	typedef struct packed {
		logic [7:0] frameErr;
		logic [7:0] crcErr;
		logic [7:0] ebitErr;
		logic [7:0] lineCode;
		logic [7:0] prbsErr;
		logic [7:0] prbsMf;
	} e1ios_ctr_t;

	// Register port request.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wrData;
		logic wr;
		logic rd;
	} e1ios_req_t;
endpackage

// ==== rtl/e1ios_status.sv ====
// Design decision made here: strobed register access.
`timescale 1ns/1ps
// Operation
// - Frame-alignment error counter wrapping FF to 00 sets word two bit 7 if unmasked.
// - CRC error counter wrapping FF to 00 sets word two bit 6 if unmasked.
// - Far-end E-bit counter wrapping FF to 00 sets word two bit 4 if unmasked.
// - Line code violation counter wrapping sets word two bit 3 if unmasked.
// - PRBS error counter wrapping sets word two bit 2 if unmasked.
// - PRBS multiframe counter overflow sets word two bit 1; mask 1 means unmasked.
// - Sa change sets word two bit 0; select picks bits or nibbles.
// - Masked events never set their status bit in words two and three.
// - Reading word three clears all its bits; reading word two clears all but bits 1 and 0.
// - Link controller 0, 1, 2 interrupts set word three bits 7, 6, 5.
// - Jitter FIFO within four bytes of over or underflow sets word three bit 4.
// - Rising edge of one-second status sets word three bit 3.
// - Rising edge of five-second status sets word three bit 2.
// - Remote alarm together with CRC error sets word three bit 1.
// - Signalling pattern change, optionally debounced, sets word three bit 0.
// - Counter overflows set latch bits 7, 6, 5, 3, 2, 1, unmasked.
// - Latch bits hold until the latch register is read, then clear.
module e1ios_status
#(
	parameter int DEBOUNCE = e1ios_pkg::DEBOUNCE_CYCLES // Signalling stable time in cycles.
)
(
	input wire logic sys_clk, // System clock, 50 MHz.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire e1ios_pkg::e1ios_req_t req, // Register port request.
	output logic [7:0] rdData, // Read data, valid the cycle after a read.
	output logic irq, // Level interrupt, high while a word two or word three bit is set.
	input wire e1ios_pkg::e1ios_ctr_t counters, // Low bytes of the error counters.
	input wire logic [3:0] saBits, // Received Sa5 to Sa8.
	input wire logic [3:0] saNibble, // Received Sa nibble.
	input wire logic saNibbleStb, // New Sa nibble valid pulse.
	input wire logic [2:0] linkCtrlIrq, // Link controller 0 to 2 interrupt pulses.
	input wire logic jitterMargin, // FIFO within four bytes of limit, level.
	input wire logic oneSecStatus, // One-second status bit.
	input wire logic fiveSecStatus, // Five-second status bit.
	input wire logic remoteAlarm, // Remote alarm event.
	input wire logic crcError, // CRC error event.
	input wire logic [3:0] sigPattern // Received AB or ABCD pattern.
);
	import e1ios_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// A wrap is the step from all ones to zero between two samples.
	function automatic logic wrapped(input logic [7:0] prev, input logic [7:0] cur);
		wrapped = (prev == COUNT_MAX) && (cur == COUNT_ZERO);
	endfunction

	localparam logic [7:0] DB_LAST = 8'(DEBOUNCE - 1);

	e1ios_ctr_t prevCtr;
	logic [3:0] saPrev;
	logic [3:0] saNibPrev;
	logic oneSecPrev;
	logic fiveSecPrev;
	logic jitterPrev;
	logic [3:0] sigStable;
	logic [3:0] sigCand;
	logic [7:0] dbCnt;
	logic [7:0] wordTwo;
	logic [7:0] wordThree;
	logic [7:0] ovfLatch;
	logic [7:0] maskTwo;
	logic [7:0] maskThree;
	logic [7:0] control;
	logic [7:0] evTwo;
	logic [7:0] evThree;
	logic [7:0] evLatch;
	logic saEvent;
	logic sigEvent;
	logic [7:0] clrTwo;
	logic [7:0] clrThree;
	logic [7:0] next_wordTwo;
	logic [7:0] next_wordThree;
	logic [7:0] next_ovfLatch;

	////////////////////////////////////////////////////////////////////////////////
	// Event detection.

	// Previous samples for edge and wrap detection.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prevCtr <= '0;
			saPrev <= 4'h0;
			saNibPrev <= 4'h0;
			oneSecPrev <= 1'b0;
			fiveSecPrev <= 1'b0;
			jitterPrev <= 1'b0;
		end
		else
		begin
			prevCtr <= counters;
			saPrev <= saBits;
			if (saNibbleStb)
				saNibPrev <= saNibble;
			oneSecPrev <= oneSecStatus;
			fiveSecPrev <= fiveSecStatus;
			jitterPrev <= jitterMargin;
		end
	end

	// Debounce keeps a candidate pattern and counts how long it has held still.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sigCand <= 4'h0;
			dbCnt <= 8'h00;
		end
		else if (sigPattern != sigCand)
		begin
			sigCand <= sigPattern;
			dbCnt <= 8'h00;
		end
		else if (dbCnt != DB_LAST)
			dbCnt <= dbCnt + 8'h01;
	end

	// Accepted pattern follows the line at once, or after the hold time when debouncing.
	assign sigEvent = (sigStable != sigPattern) &&
		(!control[BIT_DEBOUNCE_EN] || ((sigPattern == sigCand) && (dbCnt == DB_LAST)));

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			sigStable <= 4'h0;
		else if (sigEvent)
			sigStable <= sigPattern;
	end

	// Sa change in individual-bit mode or nibble mode.
	assign saEvent = control[BIT_SA_SELECT] ? (saBits != saPrev)
		: (saNibbleStb && (saNibble != saNibPrev));

	// Raw events gathered in register layout.
	always_comb
	begin
		evTwo = 8'h00;
		evTwo[BIT_FRAME_ERR] = wrapped(prevCtr.frameErr, counters.frameErr);
		evTwo[BIT_CRC_ERR] = wrapped(prevCtr.crcErr, counters.crcErr);
		evTwo[BIT_EBIT] = wrapped(prevCtr.ebitErr, counters.ebitErr);
		evTwo[BIT_LINE_CODE] = wrapped(prevCtr.lineCode, counters.lineCode);
		evTwo[BIT_PRBS_ERR] = wrapped(prevCtr.prbsErr, counters.prbsErr);
		evTwo[BIT_PRBS_MF] = wrapped(prevCtr.prbsMf, counters.prbsMf);
		evTwo[BIT_SA] = saEvent;
		evThree = 8'h00;
		evThree[BIT_LINK0] = linkCtrlIrq[0];
		evThree[BIT_LINK1] = linkCtrlIrq[1];
		evThree[BIT_LINK2] = linkCtrlIrq[2];
		evThree[BIT_JITTER] = jitterMargin && !jitterPrev;
		evThree[BIT_ONE_SEC] = oneSecStatus && !oneSecPrev;
		evThree[BIT_FIVE_SEC] = fiveSecStatus && !fiveSecPrev;
		evThree[BIT_RAI_CRC] = remoteAlarm && crcError;
		evThree[BIT_SIGNAL] = sigEvent;
		evLatch = 8'h00;
		evLatch[BIT_FRAME_ERR] = evTwo[BIT_FRAME_ERR];
		evLatch[BIT_CRC_ERR] = evTwo[BIT_CRC_ERR];
		evLatch[BIT_EBIT_LATCH] = evTwo[BIT_EBIT];
		evLatch[BIT_LINE_CODE] = evTwo[BIT_LINE_CODE];
		evLatch[BIT_PRBS_ERR] = evTwo[BIT_PRBS_ERR];
		evLatch[BIT_PRBS_MF] = evTwo[BIT_PRBS_MF];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status words.

	// A read clears the read-clear bits of word two and all of word three; a write clears the bits written as one.
	// Setting is applied after clearing so an event in the clearing cycle survives.
	always_comb
	begin
		clrTwo = 8'h00;
		clrThree = 8'h00;
		if (req.rd && (req.addr == ADDR_WORD_TWO))
			clrTwo = WORD_TWO_READ_CLEAR;
		else if (req.wr && (req.addr == ADDR_WORD_TWO))
			clrTwo = req.wrData;
		if (req.rd && (req.addr == ADDR_WORD_THREE))
			clrThree = 8'hFF;
		else if (req.wr && (req.addr == ADDR_WORD_THREE))
			clrThree = req.wrData;
		next_wordTwo = ((wordTwo & ~clrTwo) | (evTwo & maskTwo)) & WORD_TWO_USED;
		next_wordThree = (wordThree & ~clrThree) | (evThree & maskThree);
		next_ovfLatch = (req.rd && (req.addr == ADDR_OVF_LATCH)) ? evLatch : (ovfLatch | evLatch);
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wordTwo <= STATUS_RESET;
			wordThree <= STATUS_RESET;
			ovfLatch <= STATUS_RESET;
		end
		else
		begin
			wordTwo <= next_wordTwo;
			wordThree <= next_wordThree;
			ovfLatch <= next_ovfLatch & LATCH_USED;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mask and control registers.

	// Masks are active high: a one lets the event through.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			maskTwo <= MASK_RESET;
			maskThree <= MASK_RESET;
			control <= CONTROL_RESET;
		end
		else if (req.wr)
		begin
			case (req.addr)
				ADDR_MASK_TWO: maskTwo <= req.wrData & WORD_TWO_USED;
				ADDR_MASK_THREE: maskThree <= req.wrData;
				ADDR_CONTROL: control <= req.wrData & CONTROL_USED;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read port and interrupt.

	// Read data shows the value before the read's own clear; unmapped reads give zero.
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdData <= 8'h00;
		else if (req.rd)
		begin
			case (req.addr)
				ADDR_WORD_TWO: rdData <= wordTwo;
				ADDR_WORD_THREE: rdData <= wordThree;
				ADDR_OVF_LATCH: rdData <= ovfLatch;
				ADDR_MASK_TWO: rdData <= maskTwo;
				ADDR_MASK_THREE: rdData <= maskThree;
				ADDR_CONTROL: rdData <= control;
				default: rdData <= 8'h00;
			endcase
		end
		else
			rdData <= 8'h00;
	end

	// Word two and three bits are already masked at setting, so any set bit in them raises the line.
	assign irq = (wordTwo != 8'h00) || (wordThree != 8'h00);

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	sequence s_frameWrap;
		(prevCtr.frameErr == COUNT_MAX) && (counters.frameErr == COUNT_ZERO);
	endsequence

	property p_frameWrapSets;
		@(posedge sys_clk) disable iff (!rst_n)
		(s_frameWrap and maskTwo[BIT_FRAME_ERR]) |=> wordTwo[BIT_FRAME_ERR];
	endproperty
	a_frameWrapSets: assert property (p_frameWrapSets) else $error("Frame error wrap did not set word two.");

	property p_crcWrapLatch;
		@(posedge sys_clk) disable iff (!rst_n)
		((counters.crcErr == COUNT_ZERO) && ($past(counters.crcErr) == COUNT_MAX)) |=> ovfLatch[BIT_CRC_ERR];
	endproperty
	a_crcWrapLatch: assert property (p_crcWrapLatch) else $error("CRC wrap did not set the latch.");

	property p_maskedNoSet;
		@(posedge sys_clk) disable iff (!rst_n)
		(!wordThree[BIT_ONE_SEC] && !maskThree[BIT_ONE_SEC]) |=> !wordThree[BIT_ONE_SEC];
	endproperty
	a_maskedNoSet: assert property (p_maskedNoSet) else $error("Masked one-second event set its bit.");

	property p_readClears;
		@(posedge sys_clk) disable iff (!rst_n)
		(req.rd && (req.addr == ADDR_WORD_THREE) && (evThree == 8'h00)) |=> (wordThree == 8'h00);
	endproperty
	a_readClears: assert property (p_readClears) else $error("Word three read did not clear it.");

	sequence s_latchRead;
		req.rd && (req.addr == ADDR_OVF_LATCH);
	endsequence

	property p_latchHoldRead;
		@(posedge sys_clk) disable iff (!rst_n)
		(ovfLatch[BIT_LINE_CODE] && !(req.rd && (req.addr == ADDR_OVF_LATCH))) |=> ovfLatch[BIT_LINE_CODE];
	endproperty
	a_latchHoldRead: assert property (p_latchHoldRead) else $error("Latch bit dropped without a read.");

	property p_readDataNext;
		@(posedge sys_clk) disable iff (!rst_n)
		s_latchRead |=> (rdData == $past(ovfLatch));
	endproperty
	a_readDataNext: assert property (p_readDataNext) else $error("Latch read data wrong one cycle later.");

	property p_unusedZero;
		@(posedge sys_clk) disable iff (!rst_n)
		!wordTwo[5] && !ovfLatch[4] && !ovfLatch[0];
	endproperty
	a_unusedZero: assert property (p_unusedZero) else $error("Unused status bit is set.");

	property p_oneSecEdge;
		@(posedge sys_clk) disable iff (!rst_n)
		($rose(oneSecStatus) && maskThree[BIT_ONE_SEC]) |=> wordThree[BIT_ONE_SEC];
	endproperty
	a_oneSecEdge: assert property (p_oneSecEdge) else $error("One-second edge did not set word three.");

	property p_raiCrc;
		@(posedge sys_clk) disable iff (!rst_n)
		(remoteAlarm && crcError && maskThree[BIT_RAI_CRC]) |=> wordThree[BIT_RAI_CRC];
	endproperty
	a_raiCrc: assert property (p_raiCrc) else $error("Remote alarm with CRC error not flagged.");

	property p_linkIrq;
		@(posedge sys_clk) disable iff (!rst_n)
		(linkCtrlIrq[2] && maskThree[BIT_LINK2]) |=> wordThree[BIT_LINK2];
	endproperty
	a_linkIrq: assert property (p_linkIrq) else $error("Link controller 2 interrupt not flagged.");

	property p_readKeepsSa;
		@(posedge sys_clk) disable iff (!rst_n)
		(req.rd && (req.addr == ADDR_WORD_TWO) && wordTwo[BIT_SA]) |=> wordTwo[BIT_SA];
	endproperty
	a_readKeepsSa: assert property (p_readKeepsSa) else $error("Word two read cleared the Sa bit.");

	property p_readClearsTwo;
		@(posedge sys_clk) disable iff (!rst_n)
		(req.rd && (req.addr == ADDR_WORD_TWO) && (evTwo == 8'h00)) |=> ((wordTwo & WORD_TWO_READ_CLEAR) == 8'h00);
	endproperty
	a_readClearsTwo: assert property (p_readClearsTwo) else $error("Word two read left a clear-on-read bit.");

	property p_irqLevel;
		@(posedge sys_clk) disable iff (!rst_n)
		irq == ((wordTwo | wordThree) != 8'h00);
	endproperty
	a_irqLevel: assert property (p_irqLevel) else $error("Interrupt line disagrees with status.");
endmodule // e1ios_status
